// >>> src/dac_serial_pkg.sv
package dac_serial_pkg;

    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 2;
    localparam int DATA_BITS = 12;
    localparam int ADDR_MSB  = 15;
    localparam int ADDR_LSB  = 14;
    localparam int DATA_MSB  = 11;
    localparam int DATA_LSB  = 0;
    localparam int CHANNELS  = 4;

    // Queue between load strobe and channel registers
    localparam int QUEUE_WIDTH = ADDR_BITS + DATA_BITS;
    localparam int QUEUE_DEPTH = 8;

    // Pin synchroniser
    localparam int SYNC_PINS = 6;
    localparam int PIN_SCLK  = 0;
    localparam int PIN_SEL   = 1;
    localparam int PIN_SDATA = 2;
    localparam int PIN_LOAD  = 3;
    localparam int PIN_CLEAR = 4;
    localparam int PIN_LEVEL = 5;

    // Values after reset and after clear
    localparam logic [WORD_BITS-1:0] SHIFT_RESET    = 16'h0000;
    localparam logic [DATA_BITS-1:0] MIDSCALE_VALUE = 12'h800;
    localparam logic [DATA_BITS-1:0] ZERO_VALUE     = 12'h000;
    localparam logic [DATA_BITS-1:0] CHAN_RESET     = 12'h000;
    localparam logic [SYNC_PINS-1:0] SYNC_RESET     = 6'h3b;

    // Channel address decode
    typedef enum logic [1:0] {
        CHAN_A = 2'b00,
        CHAN_B = 2'b01,
        CHAN_C = 2'b10,
        CHAN_D = 2'b11
    } chan_t;

endpackage

// >>> src/quad_dac_serial_load_logic.sv
// Contract
// - While select is low, serial_in is shifted into the 16-bit shift register on each rising serial clock edge.
// - Serial clock and active-low select are ORed, so a rising select while the clock is low also shifts.
// - While select stays high the shift register ignores serial_in and never changes.
// - A word is sent MSB first: channel_sel_hi, channel_sel_lo, two fill bits, then data bit 11 down to 0.
// - Address 00, 01, 10, 11 selects channel A, B, C, D and only that channel takes the data.
// - The falling edge of load_strobe_n moves the shift register word to the addressed channel, whatever select.
// - While load_strobe_n stays low the addressed channel follows the shift register; the host must not shift then.
// - A low clear_n loads all four channels with 800 hex when clear_level_select is high, else 000 hex.
// - Clear leaves the shift register untouched.
// - Clear needs no serial clock edge and acts regardless of select.
// - After clear the channels keep the clear value until the next load strobe reloads one from the shift register.
`timescale 1ns/1ns
module quad_dac_serial_load_logic
(
    // System clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rstn,
    // Serial link pins
    input  wire logic                                 serClk,
    input  wire logic                                 selN,
    input  wire logic                                 serial_in,
    input  wire logic                                 load_strobe_n,
    // Clear pins
    input  wire logic                                 clear_n,
    input  wire logic                                 clear_level_select,
    // Converter side
    input  wire logic                                 outputHold,
    output logic [dac_serial_pkg::DATA_BITS-1:0]      chanA,
    output logic [dac_serial_pkg::DATA_BITS-1:0]      chanB,
    output logic [dac_serial_pkg::DATA_BITS-1:0]      chanC,
    output logic [dac_serial_pkg::DATA_BITS-1:0]      chanD
);
    import dac_serial_pkg::*;

    // Synchroniser stages, edge history, load request, shift and channel registers
    logic [SYNC_PINS-1:0]   syncA;
    logic [SYNC_PINS-1:0]   syncB;
    logic                   orPrev;
    logic                   loadPrev;
    logic                   shiftedD;
    logic                   pending;
    logic [WORD_BITS-1:0]   shiftReg;
    logic [DATA_BITS-1:0]   chanReg [CHANNELS];

    wire                    sSerClk;
    wire                    sSelN;
    wire                    sData;
    wire                    sLoadN;
    wire                    sClearN;
    wire                    sClSel;
    wire                    orLevel;
    wire                    shiftEvt;
    wire                    loadFall;
    wire                    pushNow;
    wire                    inValid;
    wire                    inReady;
    wire [QUEUE_WIDTH-1:0]  inData;
    wire                    outValid;
    wire                    outReady;
    wire [QUEUE_WIDTH-1:0]  outData;
    wire [ADDR_BITS-1:0]    outAddr;
    wire [DATA_BITS-1:0]    outWord;
    wire                    outFire;
    wire                    clearAct;
    wire [DATA_BITS-1:0]    clearVal;
    wire [WORD_BITS-1:0]    next_shiftReg;

    // Two-stage capture of the six serial, load and clear pins (outputHold is used directly)
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            syncA <= SYNC_RESET;
            syncB <= SYNC_RESET;
        end else begin
            syncA <= {clear_level_select, clear_n, load_strobe_n, serial_in, selN, serClk};
            syncB <= syncA;
        end
    end

    assign sSerClk  = syncB[PIN_SCLK];
    assign sSelN    = syncB[PIN_SEL];
    assign sData    = syncB[PIN_SDATA];
    assign sLoadN   = syncB[PIN_LOAD];
    assign sClearN  = syncB[PIN_CLEAR];
    assign sClSel   = syncB[PIN_LEVEL];

    // Shift clock is the OR of clock and select
    assign orLevel  = sSerClk | sSelN;
    assign shiftEvt = orLevel & ~orPrev;
    // Newest bit enters at the bottom, oldest falls off the top
    assign next_shiftReg = {shiftReg[WORD_BITS-2:0], sData};

    // Shift register, reset only by rstn
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            orPrev   <= 1'b1;
            shiftReg <= SHIFT_RESET;
            shiftedD <= 1'b0;
        end else begin
            orPrev   <= orLevel;
            shiftedD <= shiftEvt;
            if (shiftEvt) begin
                shiftReg <= next_shiftReg;
            end
        end
    end

    // Load strobe edge and transparent follow
    assign loadFall = ~sLoadN & loadPrev;
    assign pushNow  = ~sLoadN & (loadPrev | shiftedD);
    assign clearAct = ~sClearN;
    assign clearVal = sClSel ? MIDSCALE_VALUE : ZERO_VALUE;
    assign inValid  = (pushNow | pending) & ~clearAct;
    assign inData   = {shiftReg[ADDR_MSB:ADDR_LSB], shiftReg[DATA_MSB:DATA_LSB]};

    // Held request while the queue is full
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            loadPrev <= 1'b1;
            pending  <= 1'b0;
        end else begin
            loadPrev <= sLoadN;
            if (clearAct || inReady) begin
                pending <= 1'b0;
            end else if (pushNow) begin
                pending <= 1'b1;
            end
        end
    end

    sync_queue #(
        .WIDTH (QUEUE_WIDTH),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .clk      (clk),
        .rstn     (rstn),
        .flush    (clearAct),
        .inValid  (inValid),
        .inReady  (inReady),
        .inData   (inData),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (outData)
    );

    // Drain side and address decode
    assign outReady = ~outputHold;
    assign outFire  = outValid & outReady & ~clearAct;
    assign outAddr  = outData[QUEUE_WIDTH-1:DATA_BITS];
    assign outWord  = outData[DATA_BITS-1:0];

    // Channel registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                chanReg[i] <= CHAN_RESET;
            end
        end else if (clearAct) begin
            for (int i = 0; i < CHANNELS; i++) begin
                chanReg[i] <= clearVal;
            end
        end else if (outFire) begin
            chanReg[outAddr] <= outWord;
        end
    end

    assign chanA = chanReg[CHAN_A];
    assign chanB = chanReg[CHAN_B];
    assign chanC = chanReg[CHAN_C];
    assign chanD = chanReg[CHAN_D];

    // Checks
    property p_shift_in;
        @(posedge clk) disable iff (!rstn)
        shiftEvt |=> shiftReg == {$past(shiftReg[WORD_BITS-2:0]), $past(sData)};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift register did not take data bit");

    property p_select_edge;
        @(posedge clk) disable iff (!rstn)
        ($rose(sSelN) && !sSerClk && $past(!sSerClk)) |=> shiftReg[0] == $past(sData);
    endproperty
    a_select_edge: assert property (p_select_edge) else $error("select rise did not shift");

    property p_select_high;
        @(posedge clk) disable iff (!rstn)
        (sSelN && $past(sSelN)) |=> $stable(shiftReg);
    endproperty
    a_select_high: assert property (p_select_high) else $error("shift while select high");

    property p_field_split;
        @(posedge clk) disable iff (!rstn)
        inValid |-> (inData[QUEUE_WIDTH-1:DATA_BITS] == shiftReg[ADDR_MSB:ADDR_LSB])
                 && (inData[DATA_BITS-1:0] == shiftReg[DATA_MSB:DATA_LSB]);
    endproperty
    a_field_split: assert property (p_field_split) else $error("word fields misplaced");

    property p_addr_write;
        @(posedge clk) disable iff (!rstn)
        outFire |=> chanReg[$past(outAddr)] == $past(outWord);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("addressed channel not written");

    property p_load_push;
        @(posedge clk) disable iff (!rstn)
        (loadFall && sClearN) |-> inValid;
    endproperty
    a_load_push: assert property (p_load_push) else $error("load edge not forwarded");

    property p_transparent;
        @(posedge clk) disable iff (!rstn)
        (!sLoadN && shiftedD && sClearN) |-> inValid;
    endproperty
    a_transparent: assert property (p_transparent) else $error("transparent follow missing");

    property p_clear_value;
        @(posedge clk) disable iff (!rstn)
        !sClearN |=> chanReg[0] == $past(clearVal) && chanReg[1] == $past(clearVal)
                  && chanReg[2] == $past(clearVal) && chanReg[3] == $past(clearVal);
    endproperty
    a_clear_value: assert property (p_clear_value) else $error("clear value wrong");

    property p_clear_keeps_shift;
        @(posedge clk) disable iff (!rstn)
        (!sClearN && !shiftEvt) |=> $stable(shiftReg);
    endproperty
    a_clear_keeps_shift: assert property (p_clear_keeps_shift) else $error("clear touched shift register");

    property p_hold_after_clear;
        @(posedge clk) disable iff (!rstn)
        (sClearN && !outFire) |=> $stable(chanA) && $stable(chanB) && $stable(chanC) && $stable(chanD);
    endproperty
    a_hold_after_clear: assert property (p_hold_after_clear) else $error("channel changed without load");

    property p_no_drop;
        @(posedge clk) disable iff (!rstn)
        (pushNow && !inReady && sClearN) |=> pending;
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("load lost while queue full");

    property p_clear_zero;
        @(posedge clk) disable iff (!rstn)
        (!sClearN && !sClSel) |=> chanA == ZERO_VALUE && chanB == ZERO_VALUE
                               && chanC == ZERO_VALUE && chanD == ZERO_VALUE;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("zero clear value wrong");

    property p_clear_mid;
        @(posedge clk) disable iff (!rstn)
        (!sClearN && sClSel) |=> chanA == MIDSCALE_VALUE && chanB == MIDSCALE_VALUE
                              && chanC == MIDSCALE_VALUE && chanD == MIDSCALE_VALUE;
    endproperty
    a_clear_mid: assert property (p_clear_mid) else $error("midscale clear value wrong");

    property p_clear_flush;
        @(posedge clk) disable iff (!rstn)
        !sClearN |=> !outValid;
    endproperty
    a_clear_flush: assert property (p_clear_flush) else $error("queued load survived clear");

    property p_no_edge_stable;
        @(posedge clk) disable iff (!rstn)
        !shiftEvt |=> $stable(shiftReg);
    endproperty
    a_no_edge_stable: assert property (p_no_edge_stable) else $error("shift without shift edge");

    property p_clk_rise;
        @(posedge clk) disable iff (!rstn)
        ($rose(sSerClk) && !sSelN && $past(!sSelN)) |-> shiftEvt;
    endproperty
    a_clk_rise: assert property (p_clk_rise) else $error("clock rise while selected did not shift");

    property p_high_deselect;
        @(posedge clk) disable iff (!rstn)
        ($rose(sSelN) && sSerClk && $past(sSerClk)) |-> !shiftEvt;
    endproperty
    a_high_deselect: assert property (p_high_deselect) else $error("false bit on deselect");

    property p_load_idle;
        @(posedge clk) disable iff (!rstn)
        (sLoadN && !pending) |-> !inValid;
    endproperty
    a_load_idle: assert property (p_load_idle) else $error("push without load strobe");

    property p_pending_push;
        @(posedge clk) disable iff (!rstn)
        (pending && inReady && sClearN) |-> inValid;
    endproperty
    a_pending_push: assert property (p_pending_push) else $error("held load not pushed");

    property p_stall_hold;
        @(posedge clk) disable iff (!rstn)
        (outputHold && sClearN) |=> $stable(chanA) && $stable(chanB) && $stable(chanC) && $stable(chanD);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("channel changed while drain held");

    c_load:      cover property (@(posedge clk) disable iff (!rstn) loadFall && inValid);
    c_sel_shift: cover property (@(posedge clk) disable iff (!rstn) $rose(sSelN) && !sSerClk);
    c_clear_mid: cover property (@(posedge clk) disable iff (!rstn) !sClearN && sClSel);
    c_full:      cover property (@(posedge clk) disable iff (!rstn) !inReady && pending);

endmodule

// >>> src/sync_queue.sv
`timescale 1ns/1ns
module sync_queue #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             flush,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT  = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    wire              doPush;
    wire              doPop;
    wire [PW-1:0]     next_wrPtr;
    wire [PW-1:0]     next_rdPtr;

    assign inReady    = (count != FULL_COUNT);
    assign outValid   = (count != '0);
    assign outData    = mem[rdPtr];
    assign doPush     = inValid && inReady && !flush;
    assign doPop      = outValid && outReady && !flush;
    assign next_wrPtr = (wrPtr == LAST_SLOT) ? '0 : wrPtr + 1'b1;
    assign next_rdPtr = (rdPtr == LAST_SLOT) ? '0 : rdPtr + 1'b1;

    always_ff @(posedge clk) begin
        if (doPush) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else if (flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doPush) begin
                wrPtr <= next_wrPtr;
            end
            if (doPop) begin
                rdPtr <= next_rdPtr;
            end
            count <= count + CW'(doPush) - CW'(doPop);
        end
    end

endmodule

// >>> verif/host_serial_model.sv
`timescale 1ns/1ns
module host_serial_model (
    // Serial link pins
    output logic serClk,
    output logic selN,
    output logic serial_in,
    // Load strobe
    output logic load_strobe_n
);
    localparam int HALF_NS = 400;

    initial begin
        serClk        = 1'b1;
        selN          = 1'b1;
        serial_in     = 1'b0;
        load_strobe_n = 1'b1;
    end

    // Framed word, clock idles high
    task automatic send_word(input logic [15:0] w);
        selN = 1'b0;
        #HALF_NS;
        for (int i = 15; i >= 0; i--) begin
            serClk    = 1'b0;
            serial_in = w[i];
            #HALF_NS;
            serClk = 1'b1;
            #HALF_NS;
        end
        selN      = 1'b1;
        serial_in = ~serial_in;
        #HALF_NS;
    endtask

    // One bit clocked by the select edge
    task automatic select_edge_bit(input logic b);
        serClk = 1'b0;
        #HALF_NS;
        selN      = 1'b0;
        serial_in = b;
        #HALF_NS;
        selN = 1'b1;
        #HALF_NS;
        serClk    = 1'b1;
        serial_in = ~b;
        #HALF_NS;
    endtask

    // Clock toggles while deselected
    task automatic idle_clocks(input int n);
        repeat (n) begin
            serClk    = 1'b0;
            serial_in = ~serial_in;
            #HALF_NS;
            serClk = 1'b1;
            #HALF_NS;
        end
    endtask

    // Load pulse with no shifting meanwhile
    task automatic pulse_load();
        load_strobe_n = 1'b0;
        #500;
        load_strobe_n = 1'b1;
        #HALF_NS;
    endtask
endmodule

// >>> verif/quad_dac_serial_load_logic_test.sv
`timescale 1ns/1ns
module quad_dac_serial_load_logic_test;
    import dac_serial_pkg::*;
    logic                 clk;
    logic                 rstn;
    logic                 clear_n;
    logic                 clear_level_select;
    logic                 outputHold;
    wire                  serClk;
    wire                  selN;
    wire                  serial_in;
    wire                  load_strobe_n;
    wire  [DATA_BITS-1:0] chanOut [CHANNELS];
    logic [DATA_BITS-1:0] chanModel [CHANNELS];
    logic [DATA_BITS-1:0] heldModel [CHANNELS];
    logic [WORD_BITS-1:0] shiftModel;
    logic [WORD_BITS-1:0] word;
    int                   failCount;
    int                   totalChecks;
    int                   seed;

    host_serial_model hostU (
        .serClk        (serClk),
        .selN          (selN),
        .serial_in     (serial_in),
        .load_strobe_n (load_strobe_n)
    );

    quad_dac_serial_load_logic dut_u (
        .clk                (clk),
        .rstn               (rstn),
        .serClk             (serClk),
        .selN               (selN),
        .serial_in          (serial_in),
        .load_strobe_n      (load_strobe_n),
        .clear_n            (clear_n),
        .clear_level_select (clear_level_select),
        .outputHold         (outputHold),
        .chanA              (chanOut[0]),
        .chanB              (chanOut[1]),
        .chanC              (chanOut[2]),
        .chanD              (chanOut[3])
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tallyAndFinish();
        $display("checks %0d, mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_chans(input logic [DATA_BITS-1:0] exp [CHANNELS]);
        for (int i = 0; i < CHANNELS; i++) begin
            totalChecks++;
            if (chanOut[i] !== exp[i]) begin
                failCount++;
                $display("unexpected at %0t: channel %0d is %h, expected %h", $time, i, chanOut[i], exp[i]);
            end
        end
    endtask

    task automatic settle();
        repeat (12) @(negedge clk);
    endtask

    // Shift a word and strobe it into the model
    task automatic write_word(input logic [WORD_BITS-1:0] w);
        hostU.send_word(w);
        shiftModel = w;
        hostU.pulse_load();
        chanModel[w[ADDR_MSB:ADDR_LSB]] = w[DATA_MSB:DATA_LSB];
    endtask

    initial begin
        #1_000_000;
        failCount++;
        $display("unexpected at %0t: watchdog expired", $time);
        tallyAndFinish();
    end

    initial begin
        seed               = 23;
        failCount          = 0;
        totalChecks        = 0;
        rstn               = 1'b0;
        clear_n            = 1'b1;
        clear_level_select = 1'b0;
        outputHold         = 1'b0;
        shiftModel         = SHIFT_RESET;
        foreach (chanModel[i]) chanModel[i] = CHAN_RESET;
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check_chans(chanModel);
        // Every address twice, random data and fill bits
        for (int i = 0; i < 8; i++) begin
            word                    = WORD_BITS'($random(seed));
            word[ADDR_MSB:ADDR_LSB] = i[1:0];
            write_word(word);
            settle();
            check_chans(chanModel);
        end
        // Two stray bits, a word clocked only by select edges, then deselected clocks
        word = 16'h8a5c;
        hostU.select_edge_bit(1'b1);
        hostU.select_edge_bit(1'b0);
        for (int i = WORD_BITS - 1; i >= 0; i--) hostU.select_edge_bit(word[i]);
        hostU.idle_clocks(6);
        shiftModel = word;
        hostU.pulse_load();
        chanModel[word[ADDR_MSB:ADDR_LSB]] = word[DATA_MSB:DATA_LSB];
        settle();
        check_chans(chanModel);
        // Clear to midscale then zero, reload from kept shift word
        for (int c = 1; c >= 0; c--) begin
            clear_level_select = c[0];
            clear_n            = 1'b0;
            settle();
            foreach (chanModel[i]) chanModel[i] = c[0] ? MIDSCALE_VALUE : ZERO_VALUE;
            check_chans(chanModel);
            clear_n = 1'b1;
            settle();
            check_chans(chanModel);
            hostU.pulse_load();
            chanModel[shiftModel[ADDR_MSB:ADDR_LSB]] = shiftModel[DATA_MSB:DATA_LSB];
            settle();
            check_chans(chanModel);
        end
        // Stall the drain, fill the queue plus one pending
        outputHold = 1'b1;
        heldModel  = chanModel;
        for (int i = 0; i < 9; i++) begin
            word = WORD_BITS'($random(seed));
            write_word(word);
        end
        settle();
        check_chans(heldModel);
        outputHold = 1'b0;
        repeat (40) @(negedge clk);
        check_chans(chanModel);
        tallyAndFinish();
    end
endmodule
